// *** tcw_defs.svh ***
// timer compare/capture constants: widths, limits, reset values
`ifndef TCW_DEFS_SVH
`define TCW_DEFS_SVH
`define TCW_CW 32
`define TCW_PW 10
`define TCW_ZERO 32'h0000_0000
`define TCW_ONE 32'h0000_0001
`define TCW_MAX16 32'h0000_FFFF
`define TCW_MAX32 32'hFFFF_FFFF
`define TCW_PAD8 24'h00_0000
`define TCW_DIV1_LIM 10'h000
`define TCW_DIV2_LIM 10'h001
`define TCW_DIV4_LIM 10'h003
`define TCW_DIV8_LIM 10'h007
`define TCW_DIV16_LIM 10'h00F
`define TCW_DIV64_LIM 10'h03F
`define TCW_DIV256_LIM 10'h0FF
`define TCW_DIV1024_LIM 10'h3FF
`define TCW_PRESC_STEP 10'h001
`define TCW_RST_WAVE 2'h0
`endif

// *** tcw_pkg.sv ***
// timer compare/capture shared types
`default_nettype none
`include "tcw_defs.svh"
package tcw_pkg;
   typedef enum logic [1:0] {
      tcw_normal_frequency_mode = 2'h0,
      tcw_match_frequency_mode = 2'h1,
      tcw_normal_pwm_mode = 2'h2,
      tcw_match_pwm_mode = 2'h3
   } tcw_wave_t;
   typedef enum logic [1:0] {
      tcw_res16 = 2'h0,
      tcw_res8 = 2'h1,
      tcw_res32 = 2'h2
   } tcw_res_t;
   typedef enum logic [2:0] {
      tcw_act_off = 3'h0,
      tcw_act_retrigger = 3'h1,
      tcw_act_count = 3'h2,
      tcw_act_start = 3'h3,
      tcw_act_period_then_width = 3'h4,
      tcw_act_width_then_period = 3'h5
   } tcw_act_t;
   typedef struct packed {
      logic pulse;
      logic level;
   } tcw_evt_t;
   typedef struct packed {
      logic ovf;
      logic err;
      logic [1:0] mc;
   } tcw_flags_t;
   typedef struct packed {
      logic [`TCW_PW-1:0] cnt;
      logic tick;
   } tcw_presc_st_t;
   typedef struct packed {
      logic [`TCW_CW-1:0] value;
      logic flag;
   } tcw_chan_st_t;
   typedef struct packed {
      logic [`TCW_CW-1:0] count;
      logic [`TCW_CW-1:0] top_q;
      logic single_run;
      logic stopped;
      logic ovf_flag;
      logic err_flag;
      logic [1:0] wave;
      logic [1:0] pin;
      logic irq;
      logic ovf_event;
      logic [1:0] match_event;
   } tcw_st_t;
endpackage
`default_nettype wire

// *** tcw_prescale.sv ***
// prescaler: divides the generic timer clock into count ticks
`timescale 1ns/100ps
`default_nettype none
`include "tcw_defs.svh"
module tcw_prescale (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // control
   input wire logic i_run,
   input wire logic [2:0] i_divisor_sel,
   // tick out
   output logic o_tick
);
   tcw_pkg::tcw_presc_st_t s_q;
   tcw_pkg::tcw_presc_st_t s_d;
   logic [`TCW_PW-1:0] lim;

   always_comb begin
      case (i_divisor_sel)
         3'h0: lim = `TCW_DIV1_LIM;
         3'h1: lim = `TCW_DIV2_LIM;
         3'h2: lim = `TCW_DIV4_LIM;
         3'h3: lim = `TCW_DIV8_LIM;
         3'h4: lim = `TCW_DIV16_LIM;
         3'h5: lim = `TCW_DIV64_LIM;
         3'h6: lim = `TCW_DIV256_LIM;
         default: lim = `TCW_DIV1024_LIM;
      endcase
      s_d = s_q;
      s_d.tick = 1'b0;
      // halted divider restarts its phase so periods stay exact
      if (!i_run) begin
         s_d.cnt = '0;
      end else if (s_q.cnt >= lim) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + `TCW_PRESC_STEP;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_tick = s_q.tick;
endmodule
`default_nettype wire

// *** tcw_chan.sv ***
// one compare/capture channel: value register and match flag
`timescale 1ns/100ps
`default_nettype none
`include "tcw_defs.svh"
module tcw_chan (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // software side
   input wire logic i_write,
   input wire logic [`TCW_CW-1:0] i_wdata,
   input wire logic i_clear,
   // timer side
   input wire logic i_capture_en,
   input wire logic i_capture,
   input wire logic [`TCW_CW-1:0] i_stamp,
   input wire logic i_match,
   // state
   output logic [`TCW_CW-1:0] o_value,
   output logic o_flag,
   output logic o_capture_lost
);
   tcw_pkg::tcw_chan_st_t s_q;
   tcw_pkg::tcw_chan_st_t s_d;
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   logic take;

   always_comb begin
      take = i_capture & i_capture_en & ~s_q.flag;
      s_d = s_q;
      if (i_write) begin
         s_d.value = i_wdata;
      end
      if (take) begin
         s_d.value = i_stamp;
      end
      // set beats a same-cycle clear
      s_d.flag = i_match | take | (s_q.flag & ~i_clear);
   end

   assign o_capture_lost = i_capture & i_capture_en & s_q.flag;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_value = s_q.value;
   assign o_flag = s_q.flag;

   stamp_store_a: assert property (
      (take && !i_write) |=> (o_value == $past(i_stamp)) && o_flag)
      else $error("capture did not store the count");
   stamp_keep_a: assert property (
      (o_capture_lost && !i_write) |=> $stable(o_value))
      else $error("pending capture was overwritten");
endmodule
`default_nettype wire

// *** tcw_timer.sv ***
// timer compare, capture and waveform section
`timescale 1ns/100ps
`default_nettype none
`include "tcw_defs.svh"
// Overview of operation
// - channels compare on count tick; flag on next clock
// - match raises interrupt and event when enabled
// - two-bit field picks one of four modes
// - normal modes: period top, else counter max
// - normal frequency toggles output on match
// - match frequency: channel zero is top
// - pwm up: high at top, low on match
// - pwm down: low at zero, high on match
// - pwm period is divisor times top plus one
// - match pwm: output zero pulses low at wrap
// - update at top or zero sets overflow
// - up count beyond new top wraps at once
// - down reload may use previous top
// - capture event stores count as timestamp
// - capture while flag set sets error instead
// - pulse/period capture splits across both channels
// - invert bit picks wraparound edge
// - single run stops at wrap, wave zero before invert
// - set/clear single run; restarts clear stopped
// - standby halts unless run in standby
// - invert bit flips channel output
// - up wraps to zero, down reloads top
// - count tick is prescaler or event ticks
module tcw_timer (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // configuration
   input wire logic i_enable,
   input wire tcw_pkg::tcw_res_t i_resolution,
   input wire tcw_pkg::tcw_wave_t i_waveform_select,
   input wire logic [2:0] i_prescaler,
   input wire logic i_direction,
   input wire logic [7:0] i_period,
   input wire logic [1:0] i_capture_enable,
   input wire logic [1:0] i_output_invert_enable,
   // single run and commands
   input wire logic i_single_run_set,
   input wire logic i_single_run_clear,
   input wire logic i_retrigger_cmd,
   // channel value writes
   input wire logic [1:0] i_value_write,
   input wire logic [`TCW_CW-1:0] i_value_wdata,
   // flags and enables
   input wire tcw_pkg::tcw_flags_t i_flag_clear,
   input wire tcw_pkg::tcw_flags_t i_interrupt_enable_set,
   input wire logic [1:0] i_match_event_output_enable,
   input wire logic i_ovf_event_output_enable,
   // event input
   input wire logic i_event_input_enable,
   input wire logic i_event_input_invert,
   input wire tcw_pkg::tcw_act_t i_event_action,
   input wire tcw_pkg::tcw_evt_t i_event,
   // sleep
   input wire logic i_standby,
   input wire logic i_run_in_standby,
   // counter and channels
   output logic [`TCW_CW-1:0] o_count,
   output logic [`TCW_CW-1:0] o_channel_zero_value,
   output logic [`TCW_CW-1:0] o_channel_one_value,
   // status
   output tcw_pkg::tcw_flags_t o_flags,
   output logic o_stopped,
   output logic o_irq,
   // events out
   output logic [1:0] o_match_event,
   output logic o_overflow_event,
   // waveform pins
   output logic [1:0] o_waveform_output
);
   tcw_pkg::tcw_st_t s_q;
   tcw_pkg::tcw_st_t s_d;
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////
   logic [`TCW_CW-1:0] cc [2];
   logic [1:0] mc_flag;
   logic [1:0] lost;
   logic [1:0] cap;
   logic [1:0] hit;
   logic [`TCW_CW-1:0] top;
   logic presc_tick;
   logic ev;
   logic run;
   logic tick;
   logic cnt_en;
   logic upd;
   logic retrig;
   logic reload;
   logic resume;
   logic wrap_edge;
   logic pw_mode;
   logic pw_wrap;
   logic stop_now;
   logic count_act;

   assign ev = i_event_input_enable & i_event.pulse;
   assign count_act = (i_event_action == tcw_pkg::tcw_act_count);
   assign run = i_enable & ~s_q.stopped & (~i_standby | i_run_in_standby);

   tcw_prescale tcw_prescale_inst (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_run(run & ~count_act),
      .i_divisor_sel(i_prescaler),
      .o_tick(presc_tick)
   );

   assign tick = count_act ? ev : presc_tick;
   assign cnt_en = tick & run;

   ////////////////////////////////////////////////////////////////////
   // top from channel zero, period or counter max
   always_comb begin
      case (i_waveform_select)
         tcw_pkg::tcw_match_frequency_mode,
         tcw_pkg::tcw_match_pwm_mode: begin
            top = cc[0];
         end
         default: begin
            case (i_resolution)
               tcw_pkg::tcw_res8: top = {`TCW_PAD8, i_period};
               tcw_pkg::tcw_res16: top = `TCW_MAX16;
               default: top = `TCW_MAX32;
            endcase
         end
      endcase
   end

   // update at top going up, zero going down
   // greater-or-equal wraps past a lowered top
   assign upd = cnt_en & (i_direction ? (s_q.count == `TCW_ZERO)
                                      : (s_q.count >= top));

   ////////////////////////////////////////////////////////////////////
   // invert picks the wraparound edge
   assign wrap_edge = i_event.level ^ i_event_input_invert;
   assign pw_mode = (i_event_action == tcw_pkg::tcw_act_period_then_width)
                  | (i_event_action == tcw_pkg::tcw_act_width_then_period);
   assign pw_wrap = ev & pw_mode & wrap_edge;

   always_comb begin
      cap = 2'h0;
      if (i_event_action == tcw_pkg::tcw_act_off) begin
         cap = {ev, ev};
      end else if (i_event_action == tcw_pkg::tcw_act_width_then_period) begin
         cap[1] = pw_wrap;
         cap[0] = ev & ~wrap_edge;
      end else if (i_event_action == tcw_pkg::tcw_act_period_then_width) begin
         cap[0] = pw_wrap;
         cap[1] = ev & ~wrap_edge;
      end
   end

   assign retrig = i_retrigger_cmd
                 | (ev & (i_event_action == tcw_pkg::tcw_act_retrigger));
   assign reload = retrig & ~s_q.stopped;
   assign resume = s_q.stopped
                 & (retrig | (ev & (i_event_action == tcw_pkg::tcw_act_start)));
   assign stop_now = upd & s_q.single_run;

   ////////////////////////////////////////////////////////////////////
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         assign hit[gi] = cnt_en & ~i_capture_enable[gi]
                        & (s_q.count == cc[gi]);
         tcw_chan tcw_chan_inst (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_write(i_value_write[gi]),
            .i_wdata(i_value_wdata),
            .i_clear(i_flag_clear.mc[gi]),
            .i_capture_en(i_capture_enable[gi]),
            .i_capture(cap[gi]),
            .i_stamp(s_q.count),
            .i_match(hit[gi]),
            .o_value(cc[gi]),
            .o_flag(mc_flag[gi]),
            .o_capture_lost(lost[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      // registered top lags writes by one cycle
      s_d.top_q = top;
      if (reload | pw_wrap) begin
         s_d.count = (i_direction & ~pw_wrap) ? top : `TCW_ZERO;
      end else if (upd) begin
         s_d.count = i_direction ? s_q.top_q : `TCW_ZERO;
      end else if (cnt_en) begin
         s_d.count = i_direction ? s_q.count - `TCW_ONE
                                 : s_q.count + `TCW_ONE;
      end
      if (i_single_run_set) begin
         s_d.single_run = 1'b1;
      end else if (i_single_run_clear) begin
         s_d.single_run = 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
         case (i_waveform_select)
            tcw_pkg::tcw_normal_frequency_mode: begin
               if (hit[i]) begin
                  s_d.wave[i] = ~s_q.wave[i];
               end
            end
            tcw_pkg::tcw_match_frequency_mode: begin
               if (i == 0) begin
                  if (upd) begin
                     s_d.wave[i] = ~s_q.wave[i];
                  end
               end else if (hit[i]) begin
                  s_d.wave[i] = ~s_q.wave[i];
               end
            end
            tcw_pkg::tcw_match_pwm_mode: begin
               if (i == 0) begin
                  s_d.wave[i] = ~upd;
               end else if (upd) begin
                  s_d.wave[i] = ~i_direction;
               end else if (hit[i]) begin
                  s_d.wave[i] = i_direction;
               end
            end
            default: begin
               if (upd) begin
                  s_d.wave[i] = ~i_direction;
               end else if (hit[i]) begin
                  s_d.wave[i] = i_direction;
               end
            end
         endcase
      end
      if (stop_now) begin
         s_d.stopped = 1'b1;
         s_d.wave = `TCW_RST_WAVE;
      end else if (resume) begin
         s_d.stopped = 1'b0;
      end else if (s_q.stopped) begin
         s_d.wave = `TCW_RST_WAVE;
      end
      s_d.pin = s_d.wave ^ i_output_invert_enable;
      s_d.ovf_flag = upd | (s_q.ovf_flag & ~i_flag_clear.ovf);
      s_d.err_flag = (|lost) | (s_q.err_flag & ~i_flag_clear.err);
      s_d.ovf_event = upd & i_ovf_event_output_enable;
      s_d.match_event = hit & i_match_event_output_enable;
      // irq lags flags one clock; ungated by standby
      s_d.irq = |({s_q.ovf_flag, s_q.err_flag, mc_flag}
                  & i_interrupt_enable_set);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign o_count = s_q.count;
   assign o_channel_zero_value = cc[0];
   assign o_channel_one_value = cc[1];
   assign o_flags = {s_q.ovf_flag, s_q.err_flag, mc_flag};
   assign o_stopped = s_q.stopped;
   assign o_irq = s_q.irq;
   assign o_match_event = s_q.match_event;
   assign o_overflow_event = s_q.ovf_event;
   assign o_waveform_output = s_q.pin;

   ////////////////////////////////////////////////////////////////////
   match_flag_a: assert property (
      hit[0] |=> o_flags.mc[0])
      else $error("match did not set channel flag");
   match_event_a: assert property (
      (hit[1] && i_match_event_output_enable[1]) |=> o_match_event[1]
      ##1 (!o_match_event[1] || $past(hit[1])))
      else $error("match event pulse wrong");
   ovf_flag_a: assert property (
      upd |=> o_flags.ovf)
      else $error("update did not set overflow flag");
   up_wrap_a: assert property (
      (upd && !i_direction && !reload && !pw_wrap) |=> o_count == `TCW_ZERO)
      else $error("up count did not wrap to zero");
   down_reload_a: assert property (
      (upd && i_direction && !reload && !pw_wrap)
      |=> o_count == $past(s_q.top_q))
      else $error("down count did not reload top");
   lower_top_a: assert property (
      (cnt_en && !i_direction && s_q.count > top && !reload && !pw_wrap)
      |=> o_count == `TCW_ZERO)
      else $error("count above top did not wrap");
   single_run_enable_stop_a: assert property (
      (stop_now && !resume) |=> o_stopped && s_q.wave == `TCW_RST_WAVE)
      else $error("single run did not stop");
   restart_a: assert property (
      resume |=> !o_stopped)
      else $error("restart left timer stopped");
   standby_hold_a: assert property (
      (i_standby && !i_run_in_standby && !reload && !pw_wrap)
      |=> o_count == $past(o_count))
      else $error("counter moved in standby");
   normal_frequency_mode_toggle_a: assert property (
      (i_waveform_select == tcw_pkg::tcw_normal_frequency_mode && hit[0]
       && !stop_now && !s_q.stopped) |=> s_q.wave[0] != $past(s_q.wave[0]))
      else $error("normal frequency output did not toggle");
   match_pwm_mode_pulse_a: assert property (
      (i_waveform_select == tcw_pkg::tcw_match_pwm_mode && cnt_en
       && !upd && !stop_now) |=> s_q.wave[0] ##1 1'b1)
      else $error("match pwm output zero low off wrap");
   pwm_up_a: assert property (
      (i_waveform_select == tcw_pkg::tcw_normal_pwm_mode && !i_direction
       && upd && !stop_now && !s_q.stopped) |=> s_q.wave == 2'h3)
      else $error("pwm up outputs not set at top");
   pin_invert_a: assert property (
      !$past(i_rst) |-> o_waveform_output
      == (s_q.wave ^ $past(i_output_invert_enable)))
      else $error("pin does not follow invert enable");
endmodule
`default_nettype wire

// *** tcw_evnet_model.sv ***
// event network model driving the timer event input
`timescale 1ns/100ps
`default_nettype none
module tcw_evnet_model (
   // clock
   input wire logic i_ref_clk,
   // event to timer
   output var tcw_pkg::tcw_evt_t o_event
);
   initial o_event = 2'h0;
   // one-cycle event, polarity carried beside it
   task automatic send(input logic lvl);
      o_event.pulse = 1'h1;
      o_event.level = lvl;
      @(posedge i_ref_clk);
      #1;
      o_event.pulse = 1'h0;
      // released level flips so no stale edge is seen
      o_event.level = ~lvl;
   endtask
endmodule
`default_nettype wire

// *** tcw_timer_tb_top.sv ***
// bench for the timer compare, capture and waveform section
`timescale 1ns/100ps
`default_nettype none
module tcw_timer_tb_top;
   logic clk, rst, en, dir, stby, rsb, eie, einv, ss, sc, rt, oeo, w;
   tcw_pkg::tcw_res_t res;
   tcw_pkg::tcw_wave_t wv;
   tcw_pkg::tcw_act_t act;
   tcw_pkg::tcw_flags_t fc, ie, fl;
   tcw_pkg::tcw_evt_t ev;
   logic [2:0] psc;
   logic [7:0] per;
   logic [1:0] cpt, inv, vw, mceo, mev, pin;
   logic [31:0] wd, cnt, ch0, ch1, p, c;
   logic stp, irq, oev;
   int miscompares = 0;
   int num_checks = 0;
   int n;
   tcw_timer tcw_timer_inst (.i_ref_clk(clk), .i_rst(rst), .i_enable(en),
      .i_resolution(res), .i_waveform_select(wv), .i_prescaler(psc),
      .i_direction(dir), .i_period(per), .i_capture_enable(cpt),
      .i_output_invert_enable(inv), .i_single_run_set(ss),
      .i_single_run_clear(sc), .i_retrigger_cmd(rt), .i_value_write(vw),
      .i_value_wdata(wd), .i_flag_clear(fc), .i_interrupt_enable_set(ie),
      .i_match_event_output_enable(mceo), .i_ovf_event_output_enable(oeo),
      .i_event_input_enable(eie), .i_event_input_invert(einv),
      .i_event_action(act), .i_event(ev), .i_standby(stby),
      .i_run_in_standby(rsb), .o_count(cnt), .o_channel_zero_value(ch0),
      .o_channel_one_value(ch1), .o_flags(fl), .o_stopped(stp), .o_irq(irq),
      .o_match_event(mev), .o_overflow_event(oev), .o_waveform_output(pin));
   tcw_evnet_model tcw_evnet_model_inst (.i_ref_clk(clk), .o_event(ev));
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [63:0] s, e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // disabled setup, then a retrigger to start from the base value
   task automatic cfg(input tcw_pkg::tcw_wave_t m, tcw_pkg::tcw_res_t r,
         input logic d, input logic [31:0] c0, c1);
      en = 1'h0;
      wv = m;
      res = r;
      dir = d;
      vw = 2'h1;
      wd = c0;
      tk(1);
      vw = 2'h2;
      wd = c1;
      tk(1);
      vw = 2'h0;
      fc = 4'hF;
      en = 1'h1;
      rt = 1'h1;
      tk(1);
      fc = 4'h0;
      rt = 1'h0;
   endtask
   task automatic wc(input logic [31:0] v, output logic [31:0] q);
      int k;
      k = 0;
      q = cnt;
      tk(1);
      while (cnt !== v && k < 9000) begin
         q = cnt;
         tk(1);
         k++;
      end
   endtask
   task automatic wo(output int k);
      k = 1;
      tk(1);
      while (oev !== 1'h1 && k < 9000) begin
         tk(1);
         k++;
      end
   endtask
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial begin
      #40000;
      miscompares++;
      wrap_up;
   end
   initial begin
      {rst, en, dir, stby, rsb, eie, einv, ss, sc, rt, oeo} = 11'h401;
      res = tcw_pkg::tcw_res8;
      wv = tcw_pkg::tcw_normal_frequency_mode;
      act = tcw_pkg::tcw_act_off;
      // divisor one, period five
      {psc, per, cpt, inv, vw} = 17'h0_0140;
      {mceo, wd} = 34'h3_0000_0000;
      fc = 4'h0;
      ie = 4'h1;
      tk(2);
      rst = 1'h0;
      chk({cnt, fl, stp, irq, pin}, 40'h0);
      cfg(tcw_pkg::tcw_normal_frequency_mode, tcw_pkg::tcw_res8, 1'h0,
         32'h3, 32'h1);
      wc(32'h4, p);
      chk({fl.mc[0], mev[0], irq, pin}, 5'h1B);
      tk(1);
      chk({irq, mev[0]}, 2'h2);
      wc(32'h0, p);
      chk(p, 32'h5);
      chk({fl.ovf, oev, pin}, 4'hF);
      inv = 2'h1;
      cfg(tcw_pkg::tcw_normal_pwm_mode, tcw_pkg::tcw_res8, 1'h1, 32'h2, 32'h2);
      wc(32'h5, p);
      chk(p, 32'h0);
      chk({fl.ovf, pin}, 3'h5);
      wc(32'h1, p);
      chk(pin, 2'h2);
      inv = 2'h0;
      cfg(tcw_pkg::tcw_match_pwm_mode, tcw_pkg::tcw_res16, 1'h0, 32'h6, 32'h2);
      wc(32'h0, p);
      chk(p, 32'h6);
      chk(pin, 2'h2);
      tk(1);
      chk(pin, 2'h3);
      wc(32'h3, p);
      chk(pin, 2'h1);
      cfg(tcw_pkg::tcw_match_frequency_mode, tcw_pkg::tcw_res16, 1'h0,
         32'h6, 32'h9);
      wc(32'h0, p);
      w = pin[0];
      wc(32'h0, p);
      chk({p, pin[0]}, {32'h6, ~w});
      // top lowered below a running count wraps at once
      wc(32'h4, p);
      {vw, wd} = 34'h1_0000_0002;
      tk(1);
      vw = 2'h0;
      tk(1);
      chk(cnt, 32'h0);
      for (int d = 0; d < 4; d++) begin
         psc = d[2:0];
         cfg(tcw_pkg::tcw_normal_pwm_mode, tcw_pkg::tcw_res8, 1'h0,
            32'h2, 32'h2);
         wo(n);
         wo(n);
         chk(n, 32'h6 << d);
      end
      psc = 3'h0;
      cfg(tcw_pkg::tcw_normal_frequency_mode, tcw_pkg::tcw_res16, 1'h0,
         32'h0, 32'h0);
      tk(3);
      stby = 1'h1;
      tk(1);
      c = cnt;
      tk(3);
      chk(cnt, c);
      rsb = 1'h1;
      tk(2);
      c = cnt;
      tk(1);
      chk(cnt, c + 32'h1);
      {stby, rsb} = 2'h0;
      // timestamp capture on channel one only
      {cpt, eie, per} = 11'h5C8;
      cfg(tcw_pkg::tcw_normal_frequency_mode, tcw_pkg::tcw_res8, 1'h0,
         32'h0, 32'h0);
      tk(4);
      c = cnt;
      tcw_evnet_model_inst.send(1'h1);
      chk({ch1, fl.mc[1]}, {c, 1'h1});
      tk(2);
      tcw_evnet_model_inst.send(1'h0);
      chk({ch1, fl.err}, {c, 1'h1});
      cpt = 2'h3;
      for (int k = 0; k < 2; k++) begin
         act = k ? tcw_pkg::tcw_act_period_then_width
            : tcw_pkg::tcw_act_width_then_period;
         einv = k[0];
         cfg(tcw_pkg::tcw_normal_frequency_mode, tcw_pkg::tcw_res8, 1'h0,
            32'h0, 32'h0);
         tk(3);
         c = cnt;
         tcw_evnet_model_inst.send(~k[0]);
         chk({cnt, k ? ch0 : ch1}, {32'h0, c});
         tk(2);
         c = cnt;
         tcw_evnet_model_inst.send(k[0]);
         chk(k ? ch1 : ch0, c);
      end
      // counting events: only event pulses move the counter
      cpt = 2'h0;
      act = tcw_pkg::tcw_act_count;
      cfg(tcw_pkg::tcw_normal_frequency_mode, tcw_pkg::tcw_res8, 1'h0,
         32'h0, 32'h0);
      tk(3);
      tcw_evnet_model_inst.send(1'h1);
      tk(1);
      tcw_evnet_model_inst.send(1'h1);
      chk(cnt, 32'h2);
      {cpt, eie, einv, per, inv} = 14'h0_0016;
      act = tcw_pkg::tcw_act_off;
      cfg(tcw_pkg::tcw_normal_pwm_mode, tcw_pkg::tcw_res8, 1'h0, 32'h2, 32'h2);
      ss = 1'h1;
      tk(1);
      ss = 1'h0;
      n = 0;
      while (stp !== 1'h1 && n < 99) begin
         tk(1);
         n++;
      end
      chk({cnt, pin}, 34'h2);
      tk(3);
      chk({stp, cnt}, 33'h1_0000_0000);
      rt = 1'h1;
      tk(1);
      rt = 1'h0;
      tk(1);
      c = cnt;
      tk(1);
      chk({stp, cnt}, {1'h0, c + 32'h1});
      sc = 1'h1;
      tk(1);
      sc = 1'h0;
      // cleared single run must pass the next wrap
      wc(32'h0, p);
      tk(2);
      chk(stp, 1'h0);
      wrap_up;
   end
endmodule
`default_nettype wire
